// ### hdl/rcrb_top.sv
// Purpose: Receiver configuration registers, clock divider and on-time timer.
// Assumes: APB slave with zero wait states; serial number is a parameter.
// Notes: Writable registers read back their stored value, except the timer setting and the start bit.
// Functional notes
// - Top serial byte, bits 31 to 24, is read-only and fixed per chip.
// - Bit 4 of RF control disables the receive path when one.
// - Four-bit IF attenuation code, zero none, all ones maximum 12 dB.
// - Divider value is 20 bits from three registers, high one gives 19..16.
// - Clock out period is twice divider value; zero means two to twenty.
// - Oscillator bit 4 selects low side at zero, high side at one.
// - Five-bit strength slope trim from minimum 00h to maximum 1Fh.
// - Two-bit monitor select routes one of four signals to indicator pin.
// - Monitor buffer enable bit 4 switches the indicator buffer on.
// - Four-bit strength offset trim from minimum 0h to maximum Fh.
// - On-time is timer period times 14-bit value, zero meaning 16384.
// - Configurations A and B keep separate on-time and modulation registers.
// - Modulation 00 ASK, 01 FSK, 10 FSK only in polling wake search.
// - Bits 3..2 give scanned channel count in polling, unused in slave.
// - Reference timer period is 64 system cycles times the timer setting.
`timescale 1ns/1ps
module rcrb_top
    import rcrb_pkg::*;
#(
    parameter logic [7:0] SERIAL_TOP = 8'h5A // Arbitrary value.
) (
    input  wire logic        clk_sys_i,
    input  wire logic        sys_rst_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    output logic             radio_path_disable_o,
    output logic      [3:0]  intermediate_attenuation_o,
    output logic             injection_side_select_o,
    output logic      [4:0]  strength_slope_trim_o,
    output logic      [1:0]  indicator_pin_select_o,
    output logic             indicator_buffer_enable_o,
    output logic      [3:0]  strength_offset_trim_o,
    output logic             clock_out_o,
    output logic             polling_on_o,
    output logic             on_time_done_o,
    output logic             modulation_fsk_o,
    output logic      [1:0]  scan_channels_o
);

    logic [7:0]  rf_ctrl_reg;
    logic [7:0]  div_low_reg;
    logic [7:0]  div_mid_reg;
    logic [7:0]  div_high_reg;
    logic [7:0]  osc_inj_reg;
    logic [7:0]  gain_trim_reg;
    logic [7:0]  offs_mon_reg;
    logic [7:0]  on_low_reg  [2];
    logic [7:0]  on_high_reg [2];
    logic [7:0]  mod_reg     [2];
    logic [7:0]  timer_set_reg;
    logic        conf_sel_reg;
    logic [1:0]  op_mode_reg;
    logic        poll_start_reg;
    logic [31:0] prdata_reg;
    logic [19:0] div_cnt_reg;
    logic        clock_out_reg;
    logic [5:0]  pre_cnt_reg;
    logic [7:0]  rt_cnt_reg;
    logic [13:0] on_cnt_reg;
    logic        on_run_reg;
    logic        on_done_reg;

    logic        wr_en;
    logic        rd_en;
    logic [7:0]  idx;
    logic        addr_ok;
    logic [19:0] div_val;
    logic        rt_tick;
    logic [13:0] on_val;

    function automatic logic [7:0] rcrb_get(input logic [7:0] i);
        case (i)
            RCRB_IDX_SERIAL3:   rcrb_get = SERIAL_TOP;
            RCRB_IDX_RF_CTRL:   rcrb_get = rf_ctrl_reg;
            RCRB_IDX_DIV_LOW:   rcrb_get = div_low_reg;
            RCRB_IDX_DIV_MID:   rcrb_get = div_mid_reg;
            RCRB_IDX_DIV_HIGH:  rcrb_get = div_high_reg;
            RCRB_IDX_OSC_INJ:   rcrb_get = osc_inj_reg;
            RCRB_IDX_GAIN_TRIM: rcrb_get = gain_trim_reg;
            RCRB_IDX_OFFS_MON:  rcrb_get = offs_mon_reg;
            RCRB_IDX_A_ON_LOW:  rcrb_get = on_low_reg[0];
            RCRB_IDX_A_ON_HIGH: rcrb_get = on_high_reg[0];
            RCRB_IDX_A_MOD:     rcrb_get = mod_reg[0];
            RCRB_IDX_B_ON_LOW:  rcrb_get = on_low_reg[1];
            RCRB_IDX_B_ON_HIGH: rcrb_get = on_high_reg[1];
            RCRB_IDX_B_MOD:     rcrb_get = mod_reg[1];
            RCRB_IDX_STATUS:    rcrb_get = {6'h00, on_done_reg, on_run_reg};
            RCRB_IDX_SELECT:    rcrb_get = {4'h0, op_mode_reg, 1'b0, conf_sel_reg};
            default:            rcrb_get = 8'h00;
        endcase
    endfunction

    function automatic logic rcrb_known(input logic [7:0] i);
        case (i)
            RCRB_IDX_SERIAL3, RCRB_IDX_RF_CTRL, RCRB_IDX_DIV_LOW, RCRB_IDX_DIV_MID,
            RCRB_IDX_DIV_HIGH, RCRB_IDX_OSC_INJ, RCRB_IDX_GAIN_TRIM, RCRB_IDX_OFFS_MON,
            RCRB_IDX_A_ON_LOW, RCRB_IDX_A_ON_HIGH, RCRB_IDX_A_MOD, RCRB_IDX_B_ON_LOW,
            RCRB_IDX_B_ON_HIGH, RCRB_IDX_B_MOD, RCRB_IDX_STATUS, RCRB_IDX_SELECT:
                rcrb_known = 1'b1;
            default:
                rcrb_known = 1'b0;
        endcase
    endfunction

    assign idx     = paddr_i[9:2];
    assign addr_ok = rcrb_known(idx) && (paddr_i[11:10] == 2'b00) && (paddr_i[1:0] == 2'b00);
    assign wr_en   = psel_i && penable_i && pwrite_i && addr_ok;
    assign rd_en   = psel_i && !penable_i && !pwrite_i;

    // The slave always answers in the first access cycle.
    assign pready_o  = 1'b1;
    assign pslverr_o = psel_i && penable_i && !addr_ok;
    assign prdata_o  = prdata_reg;

    // Read data is captured during setup so it stands through the access phase.
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            prdata_reg <= 32'h0000_0000;
        end else if (rd_en) begin
            prdata_reg <= {24'h00_0000, rcrb_get(idx)};
        end
    end

    // Register writes; the serial byte ignores writes.
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            rf_ctrl_reg    <= RCRB_RST_RF_CTRL;
            div_low_reg    <= RCRB_RST_DIV_LOW;
            div_mid_reg    <= RCRB_RST_DIV_MID;
            div_high_reg   <= RCRB_RST_DIV_HIGH;
            osc_inj_reg    <= RCRB_RST_OSC_INJ;
            gain_trim_reg  <= RCRB_RST_GAIN_TRIM;
            offs_mon_reg   <= RCRB_RST_OFFS_MON;
            on_low_reg[0]  <= RCRB_RST_ON_LOW;
            on_low_reg[1]  <= RCRB_RST_ON_LOW;
            on_high_reg[0] <= RCRB_RST_ON_HIGH;
            on_high_reg[1] <= RCRB_RST_ON_HIGH;
            mod_reg[0]     <= RCRB_RST_MOD;
            mod_reg[1]     <= RCRB_RST_MOD;
            timer_set_reg  <= RCRB_RST_TIMER_SET;
            conf_sel_reg   <= 1'b0;
            op_mode_reg    <= RCRB_MODE_SLAVE;
            poll_start_reg <= 1'b0;
        end else begin
            poll_start_reg <= 1'b0;
            if (wr_en) begin
                case (idx)
                    RCRB_IDX_RF_CTRL:   rf_ctrl_reg    <= {3'b000, pwdata_i[4:0]};
                    RCRB_IDX_DIV_LOW:   div_low_reg    <= pwdata_i[7:0];
                    RCRB_IDX_DIV_MID:   div_mid_reg    <= pwdata_i[7:0];
                    RCRB_IDX_DIV_HIGH:  div_high_reg   <= {4'h0, pwdata_i[3:0]};
                    RCRB_IDX_OSC_INJ:   osc_inj_reg    <= pwdata_i[7:0];
                    RCRB_IDX_GAIN_TRIM: gain_trim_reg  <= {3'b000, pwdata_i[4:0]};
                    RCRB_IDX_OFFS_MON:  offs_mon_reg   <= {1'b0, pwdata_i[6:0]};
                    RCRB_IDX_A_ON_LOW:  on_low_reg[0]  <= pwdata_i[7:0];
                    RCRB_IDX_A_ON_HIGH: on_high_reg[0] <= {2'b00, pwdata_i[5:0]};
                    RCRB_IDX_A_MOD:     mod_reg[0]     <= {4'h0, pwdata_i[3:0]};
                    RCRB_IDX_B_ON_LOW:  on_low_reg[1]  <= pwdata_i[7:0];
                    RCRB_IDX_B_ON_HIGH: on_high_reg[1] <= {2'b00, pwdata_i[5:0]};
                    RCRB_IDX_B_MOD:     mod_reg[1]     <= {4'h0, pwdata_i[3:0]};
                    RCRB_IDX_STATUS:    poll_start_reg <= pwdata_i[0];
                    RCRB_IDX_SELECT: begin
                        conf_sel_reg  <= pwdata_i[0];
                        op_mode_reg   <= pwdata_i[3:2];
                        timer_set_reg <= pwdata_i[15:8];
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    assign radio_path_disable_o       = rf_ctrl_reg[RCRB_BIT_RF_OFF];
    assign intermediate_attenuation_o = rf_ctrl_reg[3:0];
    assign injection_side_select_o    = osc_inj_reg[RCRB_BIT_INJ_SIDE];
    assign strength_slope_trim_o      = gain_trim_reg[4:0];
    assign indicator_pin_select_o     = offs_mon_reg[RCRB_BIT_MON_LO +: 2];
    assign indicator_buffer_enable_o  = offs_mon_reg[RCRB_BIT_BUF_EN];
    assign strength_offset_trim_o     = offs_mon_reg[3:0];

    // Modulation decode for the selected configuration.
    always_comb begin
        case (mod_reg[conf_sel_reg][1:0])
            RCRB_MOD_ASK:   modulation_fsk_o = 1'b0;
            RCRB_MOD_FSK:   modulation_fsk_o = 1'b1;
            RCRB_MOD_MIXED: modulation_fsk_o = (op_mode_reg == RCRB_MODE_POLL);
            default:        modulation_fsk_o = 1'b0;
        endcase
    end
    assign scan_channels_o = (op_mode_reg == RCRB_MODE_SLAVE) ? 2'b00 :
                             mod_reg[conf_sel_reg][RCRB_BIT_SCAN_LO +: 2];

    // Clock divider toggles every div_val cycles; zero counts the full range.
    // A count already past a newly lowered value toggles at once and restarts.
    assign div_val = {div_high_reg[3:0], div_mid_reg, div_low_reg};
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            div_cnt_reg   <= 20'h00001;
            clock_out_reg <= 1'b0;
        end else if (div_cnt_reg == div_val ||
                     (div_val != 20'h00000 && div_cnt_reg > div_val)) begin
            div_cnt_reg   <= 20'h00001;
            clock_out_reg <= !clock_out_reg;
        end else begin
            div_cnt_reg   <= div_cnt_reg + 20'h00001;
        end
    end
    assign clock_out_o = clock_out_reg;

    // Reference timer: a 64-cycle prescaler then the timer setting, zero meaning 256.
    assign rt_tick = (pre_cnt_reg == 6'(RCRB_PRESCALE_CYC - 1)) && (rt_cnt_reg == timer_set_reg - 8'h01);
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i || poll_start_reg) begin
            pre_cnt_reg <= 6'h00;
            rt_cnt_reg  <= 8'h00;
        end else begin
            pre_cnt_reg <= pre_cnt_reg + 6'h01;
            if (pre_cnt_reg == 6'(RCRB_PRESCALE_CYC - 1)) begin
                rt_cnt_reg <= rt_tick ? 8'h00 : rt_cnt_reg + 8'h01;
            end
        end
    end

    // On-time counter for the selected configuration.
    assign on_val = {on_high_reg[conf_sel_reg][5:0], on_low_reg[conf_sel_reg]};
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            on_cnt_reg  <= 14'h0000;
            on_run_reg  <= 1'b0;
            on_done_reg <= 1'b0;
        end else if (poll_start_reg) begin
            on_cnt_reg  <= 14'h0000;
            on_run_reg  <= 1'b1;
            on_done_reg <= 1'b0;
        end else if (on_run_reg && rt_tick) begin
            on_cnt_reg <= on_cnt_reg + 14'h0001;
            if (on_cnt_reg + 14'h0001 == on_val) begin
                on_run_reg  <= 1'b0;
                on_done_reg <= 1'b1;
            end
        end
    end
    assign polling_on_o   = on_run_reg;
    assign on_time_done_o = on_done_reg;

endmodule // rcrb_top

// ### inc/rcrb_pkg.sv
// Purpose: Constants for the receiver configuration register bank.
// Assumes: APB byte addressing, index times four.
// Notes: One aligned word per 8-bit register.
package rcrb_pkg;
    localparam logic [7:0] RCRB_IDX_SERIAL3   = 8'h11;
    localparam logic [7:0] RCRB_IDX_RF_CTRL   = 8'h12;
    localparam logic [7:0] RCRB_IDX_DIV_LOW   = 8'h13;
    localparam logic [7:0] RCRB_IDX_DIV_MID   = 8'h14;
    localparam logic [7:0] RCRB_IDX_DIV_HIGH  = 8'h15;
    localparam logic [7:0] RCRB_IDX_OSC_INJ   = 8'h16;
    localparam logic [7:0] RCRB_IDX_GAIN_TRIM = 8'h1B;
    localparam logic [7:0] RCRB_IDX_OFFS_MON  = 8'h1C;
    localparam logic [7:0] RCRB_IDX_A_ON_LOW  = 8'h1F;
    localparam logic [7:0] RCRB_IDX_A_ON_HIGH = 8'h20;
    localparam logic [7:0] RCRB_IDX_A_MOD     = 8'h21;
    localparam logic [7:0] RCRB_IDX_B_ON_LOW  = 8'h40;
    localparam logic [7:0] RCRB_IDX_B_ON_HIGH = 8'h41;
    localparam logic [7:0] RCRB_IDX_B_MOD     = 8'h42;
    localparam logic [7:0] RCRB_IDX_STATUS    = 8'h50;
    localparam logic [7:0] RCRB_IDX_SELECT    = 8'h51;

    localparam logic [7:0] RCRB_RST_RF_CTRL   = 8'h00;
    localparam logic [7:0] RCRB_RST_DIV_LOW   = 8'h07;
    localparam logic [7:0] RCRB_RST_DIV_MID   = 8'h00;
    localparam logic [7:0] RCRB_RST_DIV_HIGH  = 8'h00;
    localparam logic [7:0] RCRB_RST_OSC_INJ   = 8'h00;
    localparam logic [7:0] RCRB_RST_GAIN_TRIM = 8'h0C;
    localparam logic [7:0] RCRB_RST_OFFS_MON  = 8'h15;
    localparam logic [7:0] RCRB_RST_ON_LOW    = 8'h01;
    localparam logic [7:0] RCRB_RST_ON_HIGH   = 8'h00;
    localparam logic [7:0] RCRB_RST_MOD       = 8'h04;
    localparam logic [7:0] RCRB_RST_TIMER_SET = 8'h01;

    localparam int RCRB_BIT_RF_OFF     = 4;
    localparam int RCRB_BIT_INJ_SIDE   = 4;
    localparam int RCRB_BIT_BUF_EN     = 4;
    localparam int RCRB_BIT_MON_LO     = 5;
    localparam int RCRB_BIT_SCAN_LO    = 2;
    localparam int RCRB_PRESCALE_CYC   = 64;
    localparam int RCRB_DIV_WIDTH      = 20;
    localparam int RCRB_ON_WIDTH       = 14;

    localparam logic [1:0] RCRB_MODE_SLAVE    = 2'b00;
    localparam logic [1:0] RCRB_MODE_POLL     = 2'b01;
    localparam logic [1:0] RCRB_MODE_RUN_POLL = 2'b10;
    localparam logic [1:0] RCRB_MOD_ASK       = 2'b00;
    localparam logic [1:0] RCRB_MOD_FSK       = 2'b01;
    localparam logic [1:0] RCRB_MOD_MIXED     = 2'b10;
endpackage

// ### tb/rcrb_asserts.sv
// Purpose: Port checks for the receiver configuration registers.
// Assumes: Zero wait state APB, byte address is index times four.
// Notes: Shadow registers predict the modulation outputs.
`timescale 1ns/1ps
module rcrb_asserts
    import rcrb_pkg::*;
#(
    parameter logic [7:0] SERIAL_TOP = 8'h5A
) (
    input wire logic        clk_sys_i,
    input wire logic        sys_rst_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic        radio_path_disable_o,
    input wire logic [3:0]  intermediate_attenuation_o,
    input wire logic        injection_side_select_o,
    input wire logic        polling_on_o,
    input wire logic        on_time_done_o,
    input wire logic        modulation_fsk_o,
    input wire logic [1:0]  scan_channels_o
);
    logic       acc;
    logic [7:0] idx;
    logic [3:0] mod_a_reg;
    logic [3:0] mod_b_reg;
    logic [3:0] sel_reg;
    logic [3:0] mod_cur;
    default clocking dc @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    assign acc = psel_i & penable_i & (paddr_i[11:10] == 2'b00) & (paddr_i[1:0] == 2'b00);
    assign idx = paddr_i[9:2];
    assign mod_cur = sel_reg[0] ? mod_b_reg : mod_a_reg;
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            mod_a_reg <= RCRB_RST_MOD[3:0];
            mod_b_reg <= RCRB_RST_MOD[3:0];
            sel_reg   <= 4'h0;
        end else if (acc && pwrite_i) begin
            if (idx == RCRB_IDX_A_MOD) begin
                mod_a_reg <= pwdata_i[3:0];
            end
            if (idx == RCRB_IDX_B_MOD) begin
                mod_b_reg <= pwdata_i[3:0];
            end
            if (idx == RCRB_IDX_SELECT) begin
                sel_reg <= pwdata_i[3:0];
            end
        end
    end
    apb_ready_a: assert property (pready_o) else $error("pready low");
    rf_write_a: assert property (
        acc && pwrite_i && idx == RCRB_IDX_RF_CTRL |=> radio_path_disable_o ==
        $past(pwdata_i[RCRB_BIT_RF_OFF]) && intermediate_attenuation_o == $past(pwdata_i[3:0]))
        else $error("rf control outputs wrong after write");
    inj_write_a: assert property (
        acc && pwrite_i && idx == RCRB_IDX_OSC_INJ |-> ##1
        injection_side_select_o == $past(pwdata_i[RCRB_BIT_INJ_SIDE]))
        else $error("injection side wrong after write");
    serial_read_a: assert property (
        acc && !pwrite_i && idx == RCRB_IDX_SERIAL3 |-> prdata_o[7:0] == SERIAL_TOP && !pslverr_o)
        else $error("serial byte read wrong");
    unmapped_err_a: assert property (
        psel_i && penable_i && !pwrite_i && paddr_i == 12'h000 |-> pslverr_o && prdata_o == 32'h0)
        else $error("unmapped read not refused");
    fsk_select_a: assert property (modulation_fsk_o == (mod_cur[1:0] == RCRB_MOD_FSK ||
        (mod_cur[1:0] == RCRB_MOD_MIXED && sel_reg[3:2] == RCRB_MODE_POLL)))
        else $error("modulation kind wrong");
    scan_count_a: assert property (scan_channels_o ==
        ((sel_reg[3:2] == RCRB_MODE_SLAVE) ? 2'b00 : mod_cur[3:2]))
        else $error("scan channel count wrong");
    on_done_a: assert property ($fell(polling_on_o) |-> on_time_done_o)
        else $error("on-time end without done");
    cover property (acc && pwrite_i && idx == RCRB_IDX_A_MOD);
    cover property ($fell(polling_on_o));
    cover property (psel_i && penable_i && pslverr_o);
endmodule // rcrb_asserts

bind rcrb_top rcrb_asserts #(.SERIAL_TOP(SERIAL_TOP)) rcrb_asserts_i (.clk_sys_i, .sys_rst_i,
    .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
    .radio_path_disable_o, .intermediate_attenuation_o, .injection_side_select_o,
    .polling_on_o, .on_time_done_o, .modulation_fsk_o, .scan_channels_o);

// ### tb/rcrb_top_bench.sv
// Purpose: Self-checking bench for the receiver configuration registers.
// Assumes: APB slave answers through pready, byte address is index times four.
// Notes: Divider half period and on-time are counted in system clock cycles.
`timescale 1ns/1ps
module rcrb_top_bench
    import rcrb_pkg::*;
;
    localparam logic [7:0] SER = 8'h5A; // Arbitrary value.
    localparam logic [7:0] RIDX [14] = '{8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h1B,
        8'h1C, 8'h1F, 8'h20, 8'h21, 8'h40, 8'h41, 8'h42};
    localparam logic [7:0] RVAL [14] = '{SER, 8'h00, 8'h07, 8'h00, 8'h00, 8'h00, 8'h0C,
        8'h15, 8'h01, 8'h00, 8'h04, 8'h01, 8'h00, 8'h04};
    localparam logic [7:0] VALS [5] = '{8'h1F, 8'h00, 8'h6A, 8'h35, 8'h4F};
    localparam logic [23:0] DIVS [2] = '{24'hF00102, 24'h000001};
    localparam int HALF [2] = '{258, 1};
    logic        clk_sys_i, sys_rst_i, psel_i, penable_i, pwrite_i;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, outs, rdv;
    logic        pready_o, pslverr_o, radio_path_disable_o, injection_side_select_o, errv;
    logic        indicator_buffer_enable_o, clock_out_o, polling_on_o, on_time_done_o;
    logic        modulation_fsk_o;
    logic [3:0]  intermediate_attenuation_o, strength_offset_trim_o;
    logic [4:0]  strength_slope_trim_o;
    logic [1:0]  indicator_pin_select_o, scan_channels_o;
    int          err_count, num_checks, n;

    rcrb_top #(.SERIAL_TOP(SER)) rcrb_top_i (.clk_sys_i, .sys_rst_i, .psel_i, .penable_i,
        .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .radio_path_disable_o,
        .intermediate_attenuation_o, .injection_side_select_o, .strength_slope_trim_o,
        .indicator_pin_select_o, .indicator_buffer_enable_o, .strength_offset_trim_o,
        .clock_out_o, .polling_on_o, .on_time_done_o, .modulation_fsk_o, .scan_channels_o);

    assign outs = {14'h0, radio_path_disable_o, intermediate_attenuation_o, injection_side_select_o,
        strength_slope_trim_o, indicator_pin_select_o, indicator_buffer_enable_o,
        strength_offset_trim_o};

    initial begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic hang();
        err_count++;
        $display("unexpected at %0t: wait ran out", $time);
        print_verdict();
    endtask

    // Setup cycle, then access held until pready is seen high at a rising edge.
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        psel_i   <= 1'b1;
        pwrite_i <= wr;
        paddr_i  <= {2'b00, idx, 2'b00};
        pwdata_i <= wd;
        @(posedge clk_sys_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (pready_o !== 1'b1 && n < 50);
        if (pready_o !== 1'b1) hang();
        rdv = prdata_o;
        errv = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask

    task automatic gap();
        logic c;
        c = clock_out_o;
        n = 0;
        while (clock_out_o === c && n < 3000) begin
            @(posedge clk_sys_i);
            n++;
        end
        if (clock_out_o === c) hang();
    endtask

    initial begin
        err_count = 0;
        num_checks = 0;
        sys_rst_i = 1'b1;
        psel_i = 1'b0;
        penable_i = 1'b0;
        pwrite_i = 1'b0;
        paddr_i = 12'h000;
        pwdata_i = 32'h0;
        repeat (8) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_sys_i);
        chk(outs, {14'h0, 5'h00, 1'b0, 5'h0C, 7'h15});
        for (int k = 0; k < 14; k++) begin
            apb(1'b0, RIDX[k], 32'h0);
            chk(rdv, {24'h0, RVAL[k]});
        end
        apb(1'b1, 8'h11, 32'hFF);
        apb(1'b0, 8'h11, 32'h0);
        chk(rdv, {24'h0, SER});
        apb(1'b0, 8'h00, 32'h0);
        chk({errv, rdv[30:0]}, 32'h80000000);
        for (int k = 0; k < 5; k++) begin
            apb(1'b1, 8'h12, {24'h0, VALS[k]});
            apb(1'b1, 8'h16, {24'h0, VALS[k] & 8'h10});
            apb(1'b1, 8'h1B, {24'h0, VALS[k]});
            apb(1'b1, 8'h1C, {24'h0, VALS[k]});
            chk(outs, {14'h0, VALS[k][4:0], VALS[k][4], VALS[k][4:0], VALS[k][6:0]});
        end
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, 8'h13, {24'h0, DIVS[k][7:0]});
            apb(1'b1, 8'h14, {24'h0, DIVS[k][15:8]});
            apb(1'b1, 8'h15, {24'h0, DIVS[k][23:16]});
            apb(1'b0, 8'h15, 32'h0);
            chk(rdv, {28'h0, DIVS[k][19:16]});
            gap();
            gap();
            gap();
            chk(n, HALF[k]);
        end
        apb(1'b1, 8'h42, 32'h0D);
        for (int m = 0; m < 3; m++) begin
            apb(1'b1, 8'h51, {16'h0, 8'h01, 4'h0, m[1:0], 2'b00});
            for (int c = 0; c < 3; c++) begin
                apb(1'b1, 8'h21, {28'h0, 2'b01, c[1:0]});
                chk({29'h0, modulation_fsk_o, scan_channels_o}, {29'h0, (c == 1 || (c == 2 && m == 1)), (m == 0) ? 2'b00 : 2'b01});
            end
        end
        apb(1'b1, 8'h51, {16'h0, 8'h01, 8'h05});
        chk({29'h0, modulation_fsk_o, scan_channels_o}, {29'h0, 1'b1, 2'b11});
        apb(1'b1, 8'h1F, 32'h02);
        apb(1'b1, 8'h40, 32'h33);
        apb(1'b1, 8'h51, {16'h0, 8'h01, 8'h04});
        apb(1'b0, 8'h1F, 32'h0);
        chk(rdv, 32'h02);
        apb(1'b1, 8'h50, 32'h01);
        apb(1'b0, 8'h50, 32'h0);
        chk(rdv, 32'h1);
        chk({31'h0, polling_on_o}, 32'h1);
        n = 0;
        while (on_time_done_o !== 1'b1 && n < 1000) begin
            @(posedge clk_sys_i);
            n++;
        end
        chk({31'h0, n >= 120 && n <= 130}, 32'h1);
        apb(1'b0, 8'h50, 32'h0);
        chk(rdv, 32'h2);
        chk({31'h0, polling_on_o}, 32'h0);
        print_verdict();
    end
endmodule // rcrb_top_bench
